// >>> pmd_consts.svh
// constants for the bus-master transfer control word and its engine
// assumes one 20 MHz clock and a two-bit backend register address
`ifndef PMD_CONSTS_SVH
`define PMD_CONSTS_SVH

////////////////////////////////////////////////////////////////////////
// backend register addresses
`define PMD_ADDR_PCI 2'h0
`define PMD_ADDR_RAM 2'h1
`define PMD_ADDR_CTRL 2'h2

////////////////////////////////////////////////////////////////////////
// control word bit positions
`define PMD_B_ERR_LO 0
`define PMD_B_ERR_HI 1
`define PMD_B_DONE 2
`define PMD_B_DIR 3
`define PMD_B_REQ 4
`define PMD_B_EN 5
`define PMD_B_DINT_ST 6
`define PMD_B_DINT_EN 7
`define PMD_B_XINT_ST 8
`define PMD_B_XINT_EN 9
`define PMD_B_WIDE 10
`define PMD_B_CTYPE_LO 11
`define PMD_B_CTYPE_HI 13
`define PMD_B_LEN_LO 16
`define PMD_B_LEN_WLO 18
`define PMD_B_LEN_HI 27
`define PMD_B_MB_LO 29
`define PMD_B_MB_HI 31

////////////////////////////////////////////////////////////////////////
// values
`define PMD_CORE_64 1'h1
`define PMD_LEN_MAX 13'h1000
`define PMD_STEP_32 13'h004
`define PMD_STEP_64 13'h008
`define PMD_ERR_NONE 2'h0
`define PMD_ERR_MABORT 2'h1
`define PMD_ERR_PARITY 2'h2
`define PMD_ERR_TABORT 2'h3
`define PMD_CT_MEM 3'h0
`define PMD_CT_CFG 3'h1
`define PMD_CT_IACK 3'h2
`define PMD_CT_IO 3'h4

`endif

// >>> pmd_pkg.sv
// types shared by the transfer control engine
// assumes pmd_consts.svh for numeric values
package pmd_pkg;

    // engine sequencing, one-hot
    typedef enum logic [2:0] {
        PMD_ST_IDLE = 3'h1,
        PMD_ST_BURST = 3'h2,
        PMD_ST_GAP = 3'h4
    } pmd_state_t;

    typedef logic [10:0] pmd_phase_t; // data phase count, up to 1024

endpackage : pmd_pkg

// >>> pmd_phase_counter.sv
// counts data phases within one pci burst
// assumes a clear pulse before each burst and one step per phase
`timescale 1ns/1ps
module pmd_phase_counter
    import pmd_pkg::*;
(
    input wire logic i_core_clk, // core clock
    input wire logic i_rstn, // sync reset, active low
    input wire logic i_clear, // restart count at zero
    input wire logic i_step, // one data phase taken
    output pmd_phase_t o_count // phases taken so far
);

    pmd_phase_t count_r; // running phase count
    pmd_phase_t count_nxt; // next count

    // clear wins over step: a new burst never inherits a phase
    assign count_nxt = i_clear ? '0 :
                       i_step ? pmd_phase_t'(count_r + 11'h001) : count_r;

    ////////////////////////////////////////////////////////////////////
    // count register
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign o_count = count_r;

endmodule : pmd_phase_counter

// >>> pmd_dma_control.sv
// control word and sequencing of the bus-master transfer engine
// assumes a pci master beneath it that runs the bursts it requests and
// returns one ack per data phase; registers reached over the backend port
`timescale 1ns/1ps
`include "pmd_consts.svh"
module pmd_dma_control
    import pmd_pkg::*;
(
    input wire logic i_core_clk, // 20 MHz core clock
    input wire logic i_rstn, // sync reset, active low
    input wire logic i_ctl_cs, // register chip select
    input wire logic i_ctl_rd, // register read strobe
    input wire logic i_ctl_wr, // register write strobe
    input wire logic [1:0] i_ctl_addr, // register address
    input wire logic [31:0] i_ctl_wdata, // register write data
    output logic [31:0] o_ctl_rdata, // register read data, one cycle late
    input wire logic i_phase_ack, // one data phase completed
    input wire logic i_master_abort, // master abort on pci
    input wire logic i_target_abort, // target abort on pci
    input wire logic i_parity_err, // parity error seen
    input wire logic external_interrupt_input_n, // external int, low
    output logic o_burst_req, // burst wanted, level
    output logic [10:0] o_burst_len, // phases in this burst
    output logic [2:0] o_cycle_type, // pci cycle kind
    output logic o_dir, // 1: pci to memory
    output logic o_wide, // 64-bit memory transfers
    output logic o_xfer_busy, // transfer in progress
    output logic o_pci_int_n // pci interrupt, active low
);

    ////////////////////////////////////////////////////////////////////
    // functions

    // phase limit for a burst field value, zero means no limit
    function automatic logic [6:0] burst_limit(input logic [2:0] n);
        logic [6:0] lim;
        lim = 7'h00;
        if (n != 3'h0) begin
            lim = 7'(7'h01 << (n - 3'h1));
        end
        return lim;
    endfunction : burst_limit

    // byte count loaded from a written length field
    function automatic logic [12:0] load_len(input logic [9:0] words);
        logic [12:0] len;
        len = {1'b0, words, 2'b00};
        if (words == 10'h000) begin
            len = `PMD_LEN_MAX;
        end
        return len;
    endfunction : load_len

    ////////////////////////////////////////////////////////////////////
    // state and control word fields
    pmd_state_t state_r; // engine state
    pmd_state_t state_nxt; // next engine state
    logic [1:0] err_r; // error code
    logic [1:0] err_nxt;
    logic done_r; // transfer done
    logic done_nxt;
    logic dir_r; // direction
    logic dir_nxt;
    logic req_r; // request pending or running
    logic req_nxt;
    logic en_r; // engine enable
    logic en_nxt;
    logic dint_st_r; // completion interrupt status
    logic dint_st_nxt;
    logic dint_en_r; // completion interrupt enable
    logic dint_en_nxt;
    logic xint_st_r; // external interrupt status
    logic xint_st_nxt;
    logic xint_en_r; // external interrupt enable
    logic xint_en_nxt;
    logic wide_r; // 64-bit width select
    logic wide_nxt;
    logic [2:0] ctype_r; // cycle type
    logic [2:0] ctype_nxt;
    logic [12:0] remain_r; // bytes left, 13 bits to hold 4096
    logic [12:0] remain_nxt;
    logic [2:0] mburst_r; // maximum burst field
    logic [2:0] mburst_nxt;
    logic [10:0] blen_r; // phases in current burst
    logic [10:0] blen_nxt;
    logic [31:0] rdata_r; // read data register
    logic [31:0] rdata_nxt;
    logic int_n_r; // interrupt pin register
    logic int_n_nxt;

    ////////////////////////////////////////////////////////////////////
    // decode
    wire wr_ctl; // write to control word
    wire rd_any; // read strobe
    wire idle; // engine idle
    wire in_burst; // burst running
    wire ack; // phase counted
    wire abort; // transfer killed by pci
    wire [12:0] step; // bytes per phase
    wire xfer_end; // last phase of the transfer
    wire burst_end; // last phase of this burst
    wire start; // transfer begins
    wire req_set; // software asks for a transfer
    wire [10:0] phases_left; // phases still to run
    wire [6:0] limit; // burst phase limit
    wire [10:0] next_blen; // length of the next burst
    wire [31:0] ctl_word; // assembled control word
    pmd_phase_t phase_cnt; // phases taken in this burst
    wire [10:0] phase_inc; // phase count including this ack

    assign wr_ctl = i_ctl_cs & i_ctl_wr & (i_ctl_addr == `PMD_ADDR_CTRL);
    assign rd_any = i_ctl_cs & i_ctl_rd;
    assign idle = (state_r == PMD_ST_IDLE);
    assign in_burst = (state_r == PMD_ST_BURST);
    assign ack = in_burst & i_phase_ack;
    assign abort = ~idle & (i_master_abort | i_target_abort);
    assign step = wide_r ? `PMD_STEP_64 : `PMD_STEP_32;
    assign xfer_end = ack & ~abort & (remain_r <= step);
    assign phase_inc = 11'(phase_cnt + 11'h001);
    assign burst_end = ack & ~abort & (phase_inc == blen_r);
    // enable must be one, in the word or already stored
    assign req_set = wr_ctl & i_ctl_wdata[`PMD_B_REQ]
                   & (i_ctl_wdata[`PMD_B_EN] | en_r) & idle;
    assign start = idle & req_r & en_r;

    // a 64-bit phase may carry only a trailing word
    assign phases_left = wide_r ? 11'((remain_r + `PMD_STEP_32) >> 3)
                                : 11'(remain_r >> 2);
    assign limit = burst_limit(mburst_r);
    // zero limit: whole transfer in one burst
    assign next_blen = ((limit == 7'h00) || (phases_left <= {4'h0, limit}))
                     ? phases_left : {4'h0, limit};

    // reserved bits 15:14 and 28 tie to zero
    assign ctl_word = {mburst_r, 1'b0, remain_r[11:0], 2'b00, ctype_r,
                       wide_r, xint_en_r, xint_st_r, dint_en_r, dint_st_r,
                       en_r, req_r, dir_r, done_r, err_r};

    pmd_phase_counter u_phase (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_clear(start | (state_r == PMD_ST_GAP)),
        .i_step(ack),
        .o_count(phase_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // sequencing: idle, burst, one-cycle gap between split bursts
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PMD_ST_IDLE: begin
                if (start) begin
                    state_nxt = PMD_ST_BURST;
                end
            end
            PMD_ST_BURST: begin
                if (abort || xfer_end) begin
                    state_nxt = PMD_ST_IDLE;
                end else if (burst_end) begin
                    state_nxt = PMD_ST_GAP;
                end
            end
            PMD_ST_GAP: begin
                if (abort) begin
                    state_nxt = PMD_ST_IDLE;
                end else begin
                    state_nxt = PMD_ST_BURST;
                end
            end
            default: begin
                state_nxt = PMD_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // burst length: fixed at the start of every burst
    always_comb begin
        blen_nxt = blen_r;
        if (start || (state_r == PMD_ST_GAP)) begin
            blen_nxt = next_blen;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration fields other than the three enables: frozen unless idle, so a write
    // cannot change the burst in flight
    always_comb begin
        dir_nxt = dir_r;
        en_nxt = en_r;
        dint_en_nxt = dint_en_r;
        xint_en_nxt = xint_en_r;
        wide_nxt = wide_r;
        ctype_nxt = ctype_r;
        mburst_nxt = mburst_r;
        if (wr_ctl) begin
            en_nxt = i_ctl_wdata[`PMD_B_EN];
            dint_en_nxt = i_ctl_wdata[`PMD_B_DINT_EN];
            xint_en_nxt = i_ctl_wdata[`PMD_B_XINT_EN];
            if (idle) begin
                dir_nxt = i_ctl_wdata[`PMD_B_DIR];
                // narrow build keeps the width bit at zero
                wide_nxt = i_ctl_wdata[`PMD_B_WIDE] & `PMD_CORE_64;
                // only the four defined codes are expected here
                ctype_nxt = i_ctl_wdata[`PMD_B_CTYPE_HI:`PMD_B_CTYPE_LO];
                mburst_nxt = i_ctl_wdata[`PMD_B_MB_HI:`PMD_B_MB_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // length: loaded when idle, counts down per phase
    always_comb begin
        remain_nxt = remain_r;
        if (ack && !abort) begin
            remain_nxt = (remain_r <= step) ? 13'h0000
                                            : 13'(remain_r - step);
        end else if (wr_ctl && idle) begin
            remain_nxt = load_len(
                i_ctl_wdata[`PMD_B_LEN_HI:`PMD_B_LEN_WLO]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request, done, error: hardware events win over writes
    always_comb begin
        req_nxt = req_r;
        done_nxt = done_r;
        err_nxt = err_r;
        if (req_set) begin
            req_nxt = 1'b1;
        end
        if (xfer_end || abort) begin
            req_nxt = 1'b0;
        end
        if (wr_ctl && !i_ctl_wdata[`PMD_B_DONE]) begin
            done_nxt = 1'b0;
        end
        if (xfer_end) begin
            done_nxt = 1'b1;
        end
        if (wr_ctl) begin
            err_nxt = i_ctl_wdata[`PMD_B_ERR_HI:`PMD_B_ERR_LO];
        end
        if (~idle && i_parity_err) begin
            err_nxt = `PMD_ERR_PARITY;
        end
        if (abort) begin
            err_nxt = i_target_abort ? `PMD_ERR_TABORT : `PMD_ERR_MABORT;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt status: write one clears, a new event wins
    always_comb begin
        dint_st_nxt = dint_st_r;
        xint_st_nxt = xint_st_r;
        if (wr_ctl && i_ctl_wdata[`PMD_B_DINT_ST]) begin
            dint_st_nxt = 1'b0;
        end
        if (xfer_end) begin
            dint_st_nxt = 1'b1;
        end
        if (wr_ctl && i_ctl_wdata[`PMD_B_XINT_ST]) begin
            xint_st_nxt = 1'b0;
        end
        // a held low level wins over a clear in the same cycle
        if (!external_interrupt_input_n) begin
            xint_st_nxt = 1'b1;
        end
    end

    // interrupt pin: each status gated by its own enable
    assign int_n_nxt = ~((dint_st_r & dint_en_r)
                       | (xint_st_r & xint_en_r));

    // read data: only the control word is held, others read zero
    assign rdata_nxt = !rd_any ? rdata_r :
                       (i_ctl_addr == `PMD_ADDR_CTRL) ? ctl_word : 32'h0;

    ////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            state_r <= PMD_ST_IDLE;
            blen_r <= 11'h000;
            remain_r <= 13'h0000;
            rdata_r <= 32'h0;
            int_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            blen_r <= blen_nxt;
            remain_r <= remain_nxt;
            rdata_r <= rdata_nxt;
            int_n_r <= int_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control word registers, all cleared by reset
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            err_r <= `PMD_ERR_NONE;
            done_r <= 1'b0;
            dir_r <= 1'b0;
            req_r <= 1'b0;
            en_r <= 1'b0;
            dint_st_r <= 1'b0;
            dint_en_r <= 1'b0;
            xint_st_r <= 1'b0;
            xint_en_r <= 1'b0;
            wide_r <= 1'b0;
            ctype_r <= `PMD_CT_MEM;
            mburst_r <= 3'h0;
        end else begin
            err_r <= err_nxt;
            done_r <= done_nxt;
            dir_r <= dir_nxt;
            req_r <= req_nxt;
            en_r <= en_nxt;
            dint_st_r <= dint_st_nxt;
            dint_en_r <= dint_en_nxt;
            xint_st_r <= xint_st_nxt;
            xint_en_r <= xint_en_nxt;
            wide_r <= wide_nxt;
            ctype_r <= ctype_nxt;
            mburst_r <= mburst_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops, o_burst_req decoded from state_r
    assign o_ctl_rdata = rdata_r;
    assign o_burst_req = in_burst;
    assign o_burst_len = blen_r;
    assign o_cycle_type = ctype_r;
    assign o_dir = dir_r;
    assign o_wide = wide_r;
    assign o_xfer_busy = req_r;
    assign o_pci_int_n = int_n_r;

endmodule : pmd_dma_control

// >>> pmd_pci_agent.sv
// far-side pci agent: answers bursts with one ack per data phase
// assumes the engine holds burst_len valid while burst_req is high
`timescale 1ns/1ps
module pmd_pci_agent (
    input wire logic i_core_clk, // core clock
    input wire logic i_rstn, // sync reset, active low
    input wire logic i_burst_req, // burst wanted by the engine
    input wire logic [10:0] i_burst_len, // phases in this burst
    input wire logic i_slow, // 1: ack every other cycle
    input wire logic [1:0] i_abort_sel, // 1 master, 2 target abort
    output logic o_phase_ack, // one data phase done
    output logic o_master_abort, // master abort pulse
    output logic o_target_abort // target abort pulse
);
    logic [10:0] left_r; // phases still owed in this burst
    logic seen_r; // burst_req seen last cycle
    logic tog_r; // pacing toggle for slow mode

    ////////////////////////////////////////////////////////////////////
    // acks are counted out exactly, so no stray ack lands in a gap
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            left_r <= 11'h0;
            seen_r <= 1'h0;
            tog_r <= 1'h0;
            o_phase_ack <= 1'h0;
            o_master_abort <= 1'h0;
            o_target_abort <= 1'h0;
        end else begin
            o_phase_ack <= 1'h0;
            o_master_abort <= 1'h0;
            o_target_abort <= 1'h0;
            tog_r <= ~tog_r;
            seen_r <= i_burst_req;
            if (i_burst_req && !seen_r) begin
                left_r <= i_burst_len; // new burst granted
            end else if (left_r != 11'h0 && (!i_slow || tog_r)) begin
                // abort takes the place of the second phase
                if (i_abort_sel != 2'h0 && left_r != i_burst_len) begin
                    o_master_abort <= (i_abort_sel == 2'h1);
                    o_target_abort <= (i_abort_sel == 2'h2);
                    left_r <= 11'h0;
                end else begin
                    o_phase_ack <= 1'h1;
                    left_r <= left_r - 11'h1;
                end
            end
        end
    end
endmodule : pmd_pci_agent

// >>> pmd_dma_control_assertions.sv
// port checker for the transfer control engine
// assumes one clock domain and the backend write strobe protocol
`timescale 1ns/1ps
`include "pmd_consts.svh"
module pmd_dma_control_assertions (
    input wire logic i_core_clk, // core clock
    input wire logic i_rstn, // sync reset, active low
    input wire logic i_ctl_cs, // register select
    input wire logic i_ctl_wr, // write strobe
    input wire logic [1:0] i_ctl_addr, // register address
    input wire logic [31:0] i_ctl_wdata, // write data
    input wire logic i_phase_ack, // phase done
    input wire logic i_master_abort, // master abort
    input wire logic i_target_abort, // target abort
    input wire logic external_interrupt_input_n, // ext int, low
    input wire logic o_burst_req, // burst wanted
    input wire logic [10:0] o_burst_len, // burst phases
    input wire logic [2:0] o_cycle_type, // cycle kind
    input wire logic o_dir, // direction
    input wire logic o_wide, // 64-bit memory
    input wire logic o_xfer_busy, // transfer running
    input wire logic o_pci_int_n // interrupt, low
);
    logic en_r, den_r, xen_r; // mirrors of enable bits
    logic [2:0] mb_r; // mirror of burst field
    logic [10:0] lim; // longest burst allowed
    wire wr_ctl = i_ctl_cs && i_ctl_wr && (i_ctl_addr == `PMD_ADDR_CTRL);
    assign lim = (mb_r == 3'h0) ? 11'h400 : (11'h1 << (mb_r - 3'h1));

    ////////////////////////////////////////////////////////////////////
    // enables follow every write; burst field only while not busy
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            en_r <= 1'h0;
            den_r <= 1'h0;
            xen_r <= 1'h0;
            mb_r <= 3'h0;
        end else if (wr_ctl) begin
            en_r <= i_ctl_wdata[5];
            den_r <= i_ctl_wdata[7];
            xen_r <= i_ctl_wdata[9];
            if (!o_xfer_busy) begin
                mb_r <= i_ctl_wdata[31:29];
            end
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    ////////////////////////////////////////////////////////////////////
    a_start_enable: assert property ($rose(o_xfer_busy) |->
        $past(wr_ctl) && $past(i_ctl_wdata[4]) &&
        ($past(i_ctl_wdata[5]) || $past(en_r)))
        else $error("transfer began without enable");
    a_start_delay: assert property ($rose(o_xfer_busy) |->
        !o_burst_req ##1 o_burst_req)
        else $error("burst did not follow start");
    a_burst_limit: assert property (o_burst_req |->
        (o_burst_len != 11'h0) && (o_burst_len <= lim))
        else $error("burst length outside limit");
    a_burst_gap: assert property ($fell(o_burst_req) && o_xfer_busy
        |=> o_burst_req)
        else $error("next burst late");
    a_busy_holds: assert property (o_xfer_busy && !i_phase_ack &&
        !i_master_abort && !i_target_abort |=> o_xfer_busy)
        else $error("busy dropped without cause");
    a_abort_stops: assert property (o_xfer_busy &&
        (i_master_abort || i_target_abort) |=> !o_xfer_busy && !o_burst_req)
        else $error("abort did not end transfer");
    a_ext_raises: assert property (!external_interrupt_input_n &&
        xen_r ##1 xen_r |=> !o_pci_int_n)
        else $error("external interrupt not forwarded");
    a_int_quiet: assert property (!xen_r && !den_r |=> o_pci_int_n)
        else $error("interrupt without enable");
    a_done_int: assert property ($fell(o_xfer_busy) && den_r &&
        !i_master_abort && !i_target_abort |=> !o_pci_int_n)
        else $error("completion interrupt missing");
    a_fields_hold: assert property (o_xfer_busy [*3] |->
        $stable(o_cycle_type) && $stable(o_dir) && $stable(o_wide))
        else $error("fields changed in transfer");
endmodule : pmd_dma_control_assertions

bind pmd_dma_control pmd_dma_control_assertions u_chk (.*);

// >>> tb_pmd_dma_control.sv
// self-checking bench for the transfer control engine
// assumes the pci agent model answers bursts on the far side
`timescale 1ns/1ps
`include "pmd_consts.svh"
module tb_pmd_dma_control;
    logic i_core_clk = 1'h0; // 50 ns period
    logic i_rstn = 1'h0; // low for 16 cycles
    logic i_ctl_cs = 1'h0, i_ctl_rd = 1'h0, i_ctl_wr = 1'h0; // bus strobes
    logic [1:0] i_ctl_addr = 2'h0; // register address
    logic [31:0] i_ctl_wdata = 32'h0, o_ctl_rdata; // bus data
    logic i_phase_ack, i_master_abort, i_target_abort; // from agent
    logic external_interrupt_input_n = 1'h1; // idle high
    logic o_burst_req, o_dir, o_wide, o_xfer_busy, o_pci_int_n;
    logic [10:0] o_burst_len;
    logic [2:0] o_cycle_type;
    logic slow_sel = 1'h0; // agent pacing
    logic [1:0] abort_sel = 2'h0; // agent abort kind
    int num_errors = 0, checks = 0;

    always #25 i_core_clk = ~i_core_clk;

    // parity input tied off
    pmd_dma_control u_dut (.*, .i_parity_err(1'h0));
    pmd_pci_agent u_agent (
        .i_core_clk, .i_rstn, .i_burst_req(o_burst_req),
        .i_burst_len(o_burst_len), .i_slow(slow_sel),
        .i_abort_sel(abort_sel), .o_phase_ack(i_phase_ack),
        .o_master_abort(i_master_abort), .o_target_abort(i_target_abort)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic overrun(input string nm);
        num_errors++;
        $display("MISMATCH %s exp done got timeout", nm);
        tally_and_finish();
    endtask : overrun

    // write taken at the edge after strobe rises
    task automatic wr(input logic [31:0] d);
        @(posedge i_core_clk);
        i_ctl_cs <= 1'h1;
        i_ctl_wr <= 1'h1;
        i_ctl_addr <= `PMD_ADDR_CTRL;
        i_ctl_wdata <= d;
        @(posedge i_core_clk);
        i_ctl_cs <= 1'h0;
        i_ctl_wr <= 1'h0;
    endtask : wr

    // data registered at the taking edge
    task automatic rd(input logic [1:0] a, output logic [31:0] v);
        @(posedge i_core_clk);
        i_ctl_cs <= 1'h1;
        i_ctl_rd <= 1'h1;
        i_ctl_addr <= a;
        @(posedge i_core_clk);
        i_ctl_cs <= 1'h0;
        i_ctl_rd <= 1'h0;
        #1;
        v = o_ctl_rdata;
    endtask : rd

    task automatic wait_idle();
        for (int n = 0; n < 5000; n++) begin
            @(posedge i_core_clk);
            #1;
            if (o_xfer_busy === 1'h0) return;
        end
        overrun("o_xfer_busy");
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////
    // one transfer, each burst length checked
    task automatic run_xfer(input logic [2:0] mb, input logic [11:0] len,
                            input logic wide, input logic [2:0] ct,
                            input logic dir);
        int left, lim, e, n;
        logic seen;
        logic [31:0] v;
        left = ((len == 12'h0) ? 4096 : int'(len)) / (wide ? 8 : 4);
        lim = (mb == 3'h0) ? left : (1 << (int'(mb) - 1));
        seen = 1'h0;
        @(posedge i_core_clk);
        slow_sel <= dir; // slow far side on runs with dir set
        wr({mb, 1'h0, len, 2'h0, ct, wide, 4'h2, 2'h3, dir, 3'h0});
        for (n = 0; n < 20000; n++) begin
            @(posedge i_core_clk);
            #1;
            if (o_burst_req === 1'h1 && !seen) begin
                e = (left < lim) ? left : lim;
                chk("o_burst_len", e, o_burst_len);
                left = left - e;
            end
            seen = (o_burst_req === 1'h1);
            if (o_xfer_busy !== 1'h1) break;
        end
        if (n == 20000) overrun("transfer");
        chk("phases left", 0, left);
        rd(`PMD_ADDR_CTRL, v);
        chk("ctrl word", {mb, 13'h0, 2'h0, ct, wide, 4'h3, 2'h2, dir, 3'h4},
            v);
        chk("int_n done", 1'h0, o_pci_int_n);
        chk("fields", {ct, wide, dir}, {o_cycle_type, o_wide, o_dir});
        wr(32'h40); // clears status and done, drops enable
        @(posedge i_core_clk);
        #1;
        chk("int_n cleared", 1'h1, o_pci_int_n);
    endtask : run_xfer

    task automatic t_reset();
        logic [31:0] v;
        for (int a = 0; a < 4; a++) begin
            rd(2'(a), v);
            chk("reset read", 32'h0, v);
        end
        chk("int_n reset", 1'h1, o_pci_int_n);
        $display("test reset finished");
    endtask : t_reset

    task automatic t_reserved();
        logic [31:0] v;
        wr(32'h1fff_c418); // request without enable
        repeat (3) @(posedge i_core_clk);
        #1;
        chk("busy no enable", 1'h0, o_xfer_busy);
        rd(`PMD_ADDR_CTRL, v);
        chk("reserved read", 32'h0ffc_0408, v);
        chk("dir copy", 1'h1, o_dir);
        wr(32'h0);
        $display("test reserved finished");
    endtask : t_reserved

    task automatic t_bursts();
        logic [2:0] ct [4];
        ct = '{`PMD_CT_MEM, `PMD_CT_CFG, `PMD_CT_IACK, `PMD_CT_IO};
        for (int m = 0; m < 8; m++) begin
            run_xfer(3'(m), 12'h100, 1'h0, ct[m % 4], m[0]);
        end
        run_xfer(3'h0, 12'h000, 1'h0, `PMD_CT_MEM, 1'h1);
        run_xfer(3'h3, 12'h000, 1'h1, `PMD_CT_IO, 1'h0);
        $display("test bursts finished");
    endtask : t_bursts

    task automatic t_abort();
        logic [31:0] v;
        for (int k = 1; k < 3; k++) begin
            @(posedge i_core_clk);
            abort_sel <= 2'(k);
            wr(32'h0040_0030);
            wait_idle();
            rd(`PMD_ADDR_CTRL, v);
            chk("abort word", 32'h003c_0020 | (k == 1 ? 1 : 3),
                v & ~32'h40);
            @(posedge i_core_clk);
            abort_sel <= 2'h0;
            wr(32'h0);
        end
        $display("test abort finished");
    endtask : t_abort

    task automatic t_ints();
        logic [31:0] v;
        for (int x = 1; x >= 0; x--) begin
            wr({22'h0, x[0], 9'h0});
            @(posedge i_core_clk);
            external_interrupt_input_n <= 1'h0;
            repeat (4) @(posedge i_core_clk);
            external_interrupt_input_n <= 1'h1;
            #1;
            chk("int_n ext", !x[0], o_pci_int_n);
            rd(`PMD_ADDR_CTRL, v);
            chk("ext status", {x[0], 1'h1}, v[9:8]);
            wr({22'h0, x[0], 9'h100}); // clears the status
            rd(`PMD_ADDR_CTRL, v);
            chk("ext cleared", {x[0], 1'h0}, v[9:8]);
            chk("int_n idle", 1'h1, o_pci_int_n);
        end
        $display("test ints finished");
    endtask : t_ints

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge i_core_clk);
        i_rstn <= 1'h1;
        t_reset();
        t_reserved();
        t_bursts();
        t_abort();
        t_ints();
        tally_and_finish();
    end
endmodule : tb_pmd_dma_control
